// file: logic/arsl_pkg.sv
// Purpose: Shared constants and types for the analog range status logic.
// Assumes: 16-bit signed native words, 32-bit APB data.
// Notes: Register offsets are byte addresses on the APB.
package arsl_pkg;

  // Number of analog input channels.
  localparam int CH_COUNT = 2;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_LIM_HI = 12'h004;
  localparam logic [11:0] OFS_LIM_LO = 12'h008;
  localparam logic [11:0] OFS_IN0 = 12'h00c;
  localparam logic [11:0] OFS_IN1 = 12'h010;
  localparam logic [11:0] OFS_OUT = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;
  localparam logic [11:0] OFS_DIAG = 12'h01c;

  // Control register field positions.
  localparam int CTRL_PARAM = 0;
  localparam int CTRL_GDIAG = 1;
  localparam int CTRL_DINT = 2;
  localparam int CTRL_LINT = 3;
  localparam int CTRL_LEGACY = 4;

  // Diagnostic area: two bits per channel, then the supply bit.
  localparam int DIAG_W = 5;
  localparam int DIAG_SUPPLY = 4;

  // Native format range limits.
  localparam logic signed [15:0] NAT_RATED_HI = 16'sh6c00;
  localparam logic signed [15:0] NAT_RATED_LO = 16'sh9400;
  localparam logic signed [15:0] NAT_OVR_HI = 16'sh7eff;
  localparam logic signed [15:0] NAT_UND_LO = 16'sh8100;

  // Native to legacy scale divisor and legacy range ends.
  localparam logic signed [15:0] LEG_DIV = 16'sh001b;
  localparam logic [12:0] LEG_OVF = 13'h04b5;
  localparam logic [12:0] LEG_UNF = 13'h1b4b;

  // Substitute codes.
  localparam logic [15:0] CODE_OVF = 16'h7fff;
  localparam logic [15:0] CODE_UNF = 16'h8000;
  localparam logic [15:0] CODE_INVALID = 16'h7fff;
  localparam logic [15:0] CODE_WB_LEG = 16'h06e6;
  localparam logic [15:0] CODE_ZERO = 16'h0000;

  // Reset values.
  localparam logic signed [15:0] LIM_HI_RST = 16'sh6c00;
  localparam logic signed [15:0] LIM_LO_RST = 16'sh9400;

  // Range class of one value.
  typedef enum logic [2:0] {
    CLS_RATED,
    CLS_OVER_UNDER,
    CLS_OVERFLOW,
    CLS_UNDERFLOW,
    CLS_UNPARAM,
    CLS_WIRE_BREAK
  } arsl_class_e;

  // One completed input conversion.
  typedef struct packed {
    logic valid;
    logic chan;
    logic wire_break;
    logic signed [15:0] value;
  } arsl_conv_s;

  // Whole register state of the main module.
  typedef struct packed {
    logic param_valid;
    logic group_diag_en;
    logic diag_int_en;
    logic limit_int_en;
    logic legacy_fmt;
    logic signed [15:0] lim_hi;
    logic signed [15:0] lim_lo;
    logic [15:0] out_req;
    logic [15:0] dac_value;
    logic [CH_COUNT-1:0][15:0] in_word;
    logic [CH_COUNT-1:0] outside;
    arsl_class_e [CH_COUNT-1:0] in_class;
    arsl_class_e out_class;
    logic [DIAG_W-1:0] diag;
    logic sup_meta;
    logic sup_sync;
    logic sup_prev;
    logic fault;
    logic diag_int;
    logic limit_int;
  } arsl_state_s;

endpackage

// file: logic/arsl_range_class.sv
// Purpose: Classify one analog word by range and build its reported word.
// Assumes: Value is in the signed native scale.
// Notes: Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module arsl_range_class
  import arsl_pkg::*;
(
  // Sample to classify
  input wire logic signed [15:0] value,
  input wire logic wire_break,
  // Configuration
  input wire logic param_ok,
  input wire logic legacy_fmt,
  // Result
  output arsl_class_e range_class,
  output logic [15:0] word
);

  // Value rescaled to the legacy unit count.
  logic signed [15:0] scaled;

  assign scaled = value / LEG_DIV;

  // Pick the class; parameter state and wire break come first.
  always_comb begin
    if (!param_ok) begin
      range_class = CLS_UNPARAM;
    end else if (wire_break) begin
      range_class = CLS_WIRE_BREAK;
    end else if (value > NAT_OVR_HI) begin
      range_class = CLS_OVERFLOW;
    end else if (value < NAT_UND_LO) begin
      range_class = CLS_UNDERFLOW;
    end else if (value > NAT_RATED_HI || value < NAT_RATED_LO) begin
      range_class = CLS_OVER_UNDER;
    end else begin
      range_class = CLS_RATED;
    end
  end

  // Build the reported word; bit 0 is the legacy overflow bit.
  always_comb begin
    case (range_class)
      CLS_UNPARAM: begin
        word = CODE_INVALID;
      end
      CLS_WIRE_BREAK: begin
        word = legacy_fmt ? (CODE_WB_LEG | 16'h0001) : CODE_OVF;
      end
      CLS_OVERFLOW: begin
        word = legacy_fmt ? {LEG_OVF, 3'h1} : CODE_OVF;
      end
      CLS_UNDERFLOW: begin
        word = legacy_fmt ? {LEG_UNF, 3'h1} : CODE_UNF;
      end
      default: begin
        // Measured value passes through unchanged, or scaled by LEG_DIV in legacy format.
        word = legacy_fmt ? {scaled[12:0], 3'h0} : value;
      end
    endcase
  end

endmodule

// file: logic/arsl_core.sv
// Purpose: Range status, substitute codes and fault report for analog I/O.
// Assumes: Conversions and output ticks come from logic on pclk.
// Notes: APB slave with zero wait states.
//
// Overview of operation
// - Supply failure shown and logged in diagnostics.
// - Rated and over/under-range values pass unchanged in native format.
// - Overflow and underflow load fixed substitute codes.
// - Unparameterized channel reads 7FFF, lights fault.
// - Fault light and channel entries need group diagnosis.
// - Diagnostic and limit interrupts, each behind enable.
// - Wire break loads its own code in legacy format, the overflow code 7FFF in native.
// - Outputs zeroed outside range; only unparameterized faults.
// - Input invalid until first conversion after parameters.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module arsl_core
  import arsl_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter side
  input wire arsl_conv_s conv,
  input wire logic dac_tick,
  // Supply sense pin
  input wire logic supply_ok_pin,
  // Results
  output logic [15:0] dac_value,
  output logic group_fault_indicator,
  output logic supply_indicator,
  output logic diag_int_req,
  output logic limit_int_req
);

  // Current and next register state.
  arsl_state_s s;
  arsl_state_s next_s;

  // Parameter set is usable.
  logic param_ok;

  // Classifier results for the input conversion.
  arsl_class_e in_cls;
  logic [15:0] in_cls_word;

  // Classifier result for the output word.
  arsl_class_e out_cls;

  // APB decode helpers.
  logic wr;
  logic rd;
  logic mapped;

  // Limit check on the current conversion.
  logic beyond;

  // Parameters are valid only when set and the limits are ordered.
  assign param_ok = s.param_valid && (s.lim_lo <= s.lim_hi);

  // Classify the incoming conversion.
  arsl_range_class u_in_class (
    .value(conv.value),
    .wire_break(conv.wire_break),
    .param_ok(param_ok),
    .legacy_fmt(s.legacy_fmt),
    .range_class(in_cls),
    .word(in_cls_word)
  );

  // Classify the master's output word.
  arsl_range_class u_out_class (
    .value(s.out_req),
    .wire_break(1'b0),
    .param_ok(param_ok),
    .legacy_fmt(1'b0),
    .range_class(out_cls),
    .word()
  );

  // Zero wait states; an access completes in its first access cycle.
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;

  // Address decode for the mapped word offsets.
  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_LIM_HI, OFS_LIM_LO, OFS_IN0, OFS_IN1,
      OFS_OUT, OFS_STATUS, OFS_DIAG: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Unmapped addresses answer with an error in the access phase.
  assign pslverr = psel && penable && !mapped;

  // Read mux; unused upper bits read as zero.
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      case (paddr)
        OFS_CTRL: begin
          prdata[CTRL_PARAM] = s.param_valid;
          prdata[CTRL_GDIAG] = s.group_diag_en;
          prdata[CTRL_DINT] = s.diag_int_en;
          prdata[CTRL_LINT] = s.limit_int_en;
          prdata[CTRL_LEGACY] = s.legacy_fmt;
        end
        OFS_LIM_HI: begin
          prdata[15:0] = s.lim_hi;
        end
        OFS_LIM_LO: begin
          prdata[15:0] = s.lim_lo;
        end
        OFS_IN0: begin
          prdata[15:0] = s.in_word[0];
        end
        OFS_IN1: begin
          prdata[15:0] = s.in_word[1];
        end
        OFS_OUT: begin
          prdata[15:0] = s.out_req;
        end
        OFS_STATUS: begin
          // Fault, supply, parameter state, output class, then input classes.
          prdata[0] = s.fault;
          prdata[1] = s.sup_sync;
          prdata[2] = param_ok;
          prdata[6:4] = s.out_class;
          prdata[10:8] = s.in_class[0];
          prdata[14:12] = s.in_class[1];
        end
        OFS_DIAG: begin
          prdata[DIAG_W-1:0] = s.diag;
        end
        default: begin
          prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Limit crossing is judged only for a real measured value.
  assign beyond = (conv.value > s.lim_hi) || (conv.value < s.lim_lo);

  // Next state: conversions, output ticks, bus writes, then flag sets.
  always_comb begin
    next_s = s;
    // Interrupt requests are single-cycle pulses.
    next_s.diag_int = 1'b0;
    next_s.limit_int = 1'b0;

    // Supply sense passes two flops before any logic reads it.
    next_s.sup_meta = supply_ok_pin;
    next_s.sup_sync = s.sup_meta;
    next_s.sup_prev = s.sup_sync;

    // A finished conversion reclassifies its channel.
    if (conv.valid) begin
      next_s.in_word[conv.chan] = in_cls_word;
      next_s.in_class[conv.chan] = in_cls;
      // Overflow and underflow raise a diagnostic interrupt.
      if ((in_cls == CLS_OVERFLOW || in_cls == CLS_UNDERFLOW) &&
          s.diag_int_en) begin
        next_s.diag_int = 1'b1;
      end
      // Limit request only when the value newly leaves the band.
      if (in_cls == CLS_RATED || in_cls == CLS_OVER_UNDER) begin
        next_s.outside[conv.chan] = beyond;
        if (beyond && !s.outside[conv.chan] && s.limit_int_en) begin
          next_s.limit_int = 1'b1;
        end
      end else begin
        next_s.outside[conv.chan] = 1'b0;
      end
    end

    // The output follows the master only inside its valid range.
    if (dac_tick) begin
      next_s.out_class = out_cls;
      if (out_cls == CLS_RATED || out_cls == CLS_OVER_UNDER) begin
        next_s.dac_value = s.out_req;
      end else begin
        next_s.dac_value = CODE_ZERO;
      end
    end

    // Register writes; parameter writes restart the input words.
    if (wr && mapped) begin
      case (paddr)
        OFS_CTRL: begin
          next_s.param_valid = pwdata[CTRL_PARAM];
          next_s.group_diag_en = pwdata[CTRL_GDIAG];
          next_s.diag_int_en = pwdata[CTRL_DINT];
          next_s.limit_int_en = pwdata[CTRL_LINT];
          next_s.legacy_fmt = pwdata[CTRL_LEGACY];
          // Input invalid until the next conversion.
          next_s.in_word = {CH_COUNT{CODE_INVALID}};
          next_s.outside = '0;
        end
        OFS_LIM_HI: begin
          next_s.lim_hi = pwdata[15:0];
          next_s.in_word = {CH_COUNT{CODE_INVALID}};
        end
        OFS_LIM_LO: begin
          next_s.lim_lo = pwdata[15:0];
          next_s.in_word = {CH_COUNT{CODE_INVALID}};
        end
        OFS_OUT: begin
          // Held until the next output tick applies it.
          next_s.out_req = pwdata[15:0];
        end
        OFS_DIAG: begin
          // Write one to clear an entry.
          next_s.diag = s.diag & ~pwdata[DIAG_W-1:0];
        end
        default: begin
          next_s.diag = next_s.diag;
        end
      endcase
    end

    // Entries set after the clear so a same-cycle event survives.
    if (s.sup_prev && !s.sup_sync) begin
      next_s.diag[DIAG_SUPPLY] = 1'b1;
    end
    if (conv.valid && s.group_diag_en) begin
      if (in_cls == CLS_OVERFLOW) begin
        next_s.diag[{conv.chan, 1'b0}] = 1'b1;
      end
      if (in_cls == CLS_UNDERFLOW) begin
        next_s.diag[{conv.chan, 1'b1}] = 1'b1;
      end
    end

    // Group fault: parameter state or a channel out of range.
    next_s.fault = 1'b0;
    if (next_s.group_diag_en) begin
      if (!(next_s.param_valid &&
            (next_s.lim_lo <= next_s.lim_hi))) begin
        next_s.fault = 1'b1;
      end
      for (int c = 0; c < CH_COUNT; c++) begin
        if (next_s.in_class[c] == CLS_OVERFLOW ||
            next_s.in_class[c] == CLS_UNDERFLOW) begin
          next_s.fault = 1'b1;
        end
      end
    end
  end

  // State register; reset leaves inputs invalid and outputs at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.param_valid <= 1'b0;
      s.group_diag_en <= 1'b0;
      s.diag_int_en <= 1'b0;
      s.limit_int_en <= 1'b0;
      s.legacy_fmt <= 1'b0;
      s.lim_hi <= LIM_HI_RST;
      s.lim_lo <= LIM_LO_RST;
      s.out_req <= CODE_ZERO;
      s.dac_value <= CODE_ZERO;
      s.in_word <= {CH_COUNT{CODE_INVALID}};
      s.outside <= '0;
      s.in_class <= '{default: CLS_UNPARAM};
      s.out_class <= CLS_UNPARAM;
      s.diag <= '0;
      s.sup_meta <= 1'b0;
      s.sup_sync <= 1'b0;
      s.sup_prev <= 1'b0;
      s.fault <= 1'b0;
      s.diag_int <= 1'b0;
      s.limit_int <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from state flops.
  assign dac_value = s.dac_value;
  assign group_fault_indicator = s.fault;
  assign supply_indicator = s.sup_sync;
  assign diag_int_req = s.diag_int;
  assign limit_int_req = s.limit_int;

endmodule

// file: testbench/arsl_core_props.sv
// Purpose: Port-level checks on the analog range status core.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Bound into every instance of the core.
`timescale 1ns/1ps
module arsl_core_props
  import arsl_pkg::*;
(
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Converter side and results
  input wire arsl_conv_s conv,
  input wire logic dac_tick,
  input wire logic supply_ok_pin,
  input wire logic [15:0] dac_value,
  input wire logic supply_indicator,
  input wire logic diag_int_req,
  input wire logic limit_int_req
);
  // All checks share the bus clock and its reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_sup;
    !supply_ok_pin [*4] |-> !supply_indicator;
  endproperty
  a_sup: assert property (p_sup) else $error("supply lamp stays on");
  property p_dint;
    diag_int_req |-> $past(conv.valid) && !$past(conv.wire_break) &&
      ($past(conv.value) > NAT_OVR_HI || $past(conv.value) < NAT_UND_LO);
  endproperty
  a_dint: assert property (p_dint) else $error("stray diag request");
  property p_lint;
    limit_int_req |-> $past(conv.valid) && !$past(conv.wire_break);
  endproperty
  a_lint: assert property (p_lint) else $error("stray limit request");
  property p_dac;
    $changed(dac_value) |-> $past(dac_tick);
  endproperty
  a_dac: assert property (p_dac) else $error("output moved untimed");
  property p_dzero;
    dac_value != 16'h0000 |->
      $signed(dac_value) <= NAT_OVR_HI && $signed(dac_value) >= NAT_UND_LO;
  endproperty
  a_dzero: assert property (p_dzero) else $error("output overflow");
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_unm;
    psel && penable && paddr > OFS_DIAG |-> pslverr && pready;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_upper;
    psel && penable && !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper half not zero");
  property p_inval;
    psel && penable && pwrite && paddr == OFS_CTRL ##1 !conv.valid [*2]
      ##1 psel && penable && !pwrite && paddr == OFS_IN0
      |-> prdata == 32'h0000_7fff;
  endproperty
  a_inval: assert property (p_inval) else $error("input not invalid");
endmodule

bind arsl_core arsl_core_props chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv(conv),
  .dac_tick(dac_tick), .supply_ok_pin(supply_ok_pin),
  .dac_value(dac_value), .supply_indicator(supply_indicator),
  .diag_int_req(diag_int_req), .limit_int_req(limit_int_req));

// file: testbench/arsl_master_model.sv
// Purpose: Far-side model feeding conversions, output ticks and supply.
// Assumes: Everything moves right after a rising pclk edge.
// Notes: A released data field shows the inverse of its last value.
`timescale 1ns/1ps
module arsl_master_model
  import arsl_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Toward the block
  output arsl_conv_s conv,
  output logic dac_tick,
  output logic supply_ok_pin
);
  // Idle lines and a healthy supply at time zero.
  initial begin
    conv = '0;
    dac_tick = 1'b0;
    supply_ok_pin = 1'b1;
  end
  // One conversion pulse, then the value field goes stale.
  task automatic send_conv(input logic ch, wb, input logic [15:0] v);
    @(posedge pclk);
    conv <= {1'b1, ch, wb, v};
    @(posedge pclk);
    conv <= {1'b0, ch, 1'b0, ~v};
  endtask
  // One output conversion moment.
  task automatic tick();
    @(posedge pclk);
    dac_tick <= 1'b1;
    @(posedge pclk);
    dac_tick <= 1'b0;
  endtask
  // Supply sense level.
  task automatic supply(input logic lvl);
    @(posedge pclk);
    supply_ok_pin <= lvl;
  endtask
endmodule

// file: testbench/test_analog_range_status_logic.sv
// Purpose: Self-checking bench for the analog range status core.
// Assumes: Zero wait state APB, conversions from the master model.
// Notes: Each scenario is one task; the run ends in stop_test.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module test_analog_range_status_logic;
  import arsl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, dac_tick, supply_ok_pin;
  arsl_conv_s conv;
  logic [15:0] dac_value;
  logic group_fault_indicator, supply_indicator;
  logic diag_int_req, limit_int_req;
  int error_cnt = 0, total_checks = 0, dcnt = 0, lcnt = 0;
  arsl_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv(conv),
    .dac_tick(dac_tick), .supply_ok_pin(supply_ok_pin),
    .dac_value(dac_value), .group_fault_indicator(group_fault_indicator),
    .supply_indicator(supply_indicator), .diag_int_req(diag_int_req),
    .limit_int_req(limit_int_req));
  arsl_master_model pm_u (.pclk(pclk), .conv(conv), .dac_tick(dac_tick),
    .supply_ok_pin(supply_ok_pin));
  // Free-running clock at 8 ns.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Count interrupt request pulses as they pass.
  always @(posedge pclk) begin
    if (diag_int_req === 1'b1) dcnt++;
    if (limit_int_req === 1'b1) lcnt++;
  end
  // One APB transfer: setup, access, take the answer when ready.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("read data", ex, r)
  endtask
  // Set control, see the invalid code, convert, judge the outcome.
  task automatic conv_case(input logic [4:0] c, input logic ch, wb,
    input logic [15:0] v, w, input logic di, f);
    int d0;
    wr(OFS_CTRL, {27'h0, c});
    rd(ch ? OFS_IN1 : OFS_IN0, 32'h7fff);
    d0 = dcnt;
    pm_u.send_conv(ch, wb, v);
    repeat (3) @(posedge pclk);
    rd(ch ? OFS_IN1 : OFS_IN0, {16'h0, w});
    `CHK("diag request", di, dcnt != d0)
    `CHK("fault lamp", f, group_fault_indicator)
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_LIM_HI, 32'h6c00);
    rd(OFS_LIM_LO, 32'h9400);
    rd(OFS_IN0, 32'h7fff);
    rd(OFS_IN1, 32'h7fff);
    apb(1'b0, 12'h020, 32'h0, r, e);
    `CHK("unmapped error", 1'b1, e)
  endtask
  task automatic t_gate();
    conv_case(5'h01, 1'b0, 1'b0, 16'h7f00, 16'h7fff, 1'b0, 1'b0);
    rd(OFS_DIAG, 32'h0);
  endtask
  task automatic t_pass();
    conv_case(5'h0d, 1'b0, 1'b0, 16'h1234, 16'h1234, 1'b0, 1'b0);
    conv_case(5'h0d, 1'b0, 1'b0, 16'h7000, 16'h7000, 1'b0, 1'b0);
    conv_case(5'h1d, 1'b0, 1'b0, 16'h1234, 16'h0560, 1'b0, 1'b0);
  endtask
  task automatic t_flow();
    conv_case(5'h0f, 1'b0, 1'b0, 16'h7f00, 16'h7fff, 1'b1, 1'b1);
    conv_case(5'h0f, 1'b1, 1'b0, 16'h8000, 16'h8000, 1'b1, 1'b1);
    rd(OFS_DIAG, 32'h9);
    conv_case(5'h1f, 1'b0, 1'b0, 16'h7f00, 16'h25a9, 1'b1, 1'b1);
    conv_case(5'h1f, 1'b1, 1'b0, 16'h8000, 16'hda59, 1'b1, 1'b1);
  endtask
  task automatic t_wire();
    conv_case(5'h19, 1'b0, 1'b1, 16'h0100, 16'h06e7, 1'b0, 1'b0);
    conv_case(5'h09, 1'b0, 1'b1, 16'h0100, 16'h7fff, 1'b0, 1'b0);
  endtask
  task automatic t_unparam();
    conv_case(5'h02, 1'b0, 1'b0, 16'h1234, 16'h7fff, 1'b0, 1'b1);
    // Fault, supply ok, output unparameterized, ch0 unparam, ch1 underflow.
    rd(OFS_STATUS, 32'h3443);
    // Lower limit above the upper one is an invalid parameter set.
    wr(OFS_LIM_LO, 32'h7000);
    conv_case(5'h03, 1'b0, 1'b0, 16'h1234, 16'h7fff, 1'b0, 1'b1);
    wr(OFS_LIM_LO, 32'h9400);
  endtask
  // Inside the limits first, then above the upper one.
  task automatic t_limit();
    int l0;
    wr(OFS_CTRL, 32'h9);
    wr(OFS_LIM_HI, 32'h1000);
    l0 = lcnt;
    pm_u.send_conv(1'b0, 1'b0, 16'h0800);
    pm_u.send_conv(1'b0, 1'b0, 16'h2000);
    repeat (3) @(posedge pclk);
    `CHK("limit pulses", 1, lcnt - l0)
  endtask
  task automatic dac_case(input logic [4:0] c, input logic [15:0] o, ex);
    wr(OFS_CTRL, {27'h0, c});
    wr(OFS_OUT, {16'h0, o});
    pm_u.tick();
    @(posedge pclk);
    `CHK("output word", ex, dac_value)
  endtask
  task automatic t_dac();
    dac_case(5'h01, 16'h1234, 16'h1234);
    // A new parameter set leaves the output at its previous value.
    wr(OFS_CTRL, 32'h1);
    `CHK("held output", 16'h1234, dac_value)
    dac_case(5'h01, 16'h7f00, 16'h0000);
    dac_case(5'h01, 16'h8000, 16'h0000);
    dac_case(5'h00, 16'h1234, 16'h0000);
  endtask
  // Supply drop shows on the lamp and in the diagnostic word.
  task automatic t_supply();
    wr(OFS_DIAG, 32'h1f);
    pm_u.supply(1'b0);
    repeat (6) @(posedge pclk);
    `CHK("supply lamp", 1'b0, supply_indicator)
    rd(OFS_DIAG, 32'h10);
    pm_u.supply(1'b1);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cut a hang short.
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
  // Reset, then the scenarios in order.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_gate();
    t_pass();
    t_flow();
    t_wire();
    t_unparam();
    t_limit();
    t_dac();
    t_supply();
    stop_test();
  end
endmodule
